// >>> verilog/osciw_pkg.sv
package osciw_pkg;

	// ***********************************************
	// serial link timing
	// ***********************************************
	localparam int CLK_FREQ_MHZ  = 100;                                   // system clock rate
	localparam int SCLK_HALF_NS  = 50;                                    // least half period of serial clock
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_FREQ_MHZ + 999) / 1000; // rounded up to cycles
	localparam int FRAME_BITS    = 32;                                    // bits shifted per register write
	localparam logic [4:0] DIV_LAST   = 5'(SCLK_HALF_CYC - 1);            // last divider count
	localparam logic [5:0] BIT_LAST   = 6'h1f;                            // index of the last frame bit
	localparam logic [2:0] FRAME_TAIL = 3'h0;                             // trailing chip field of a frame

	// ***********************************************
	// synthesizer register addresses
	// ***********************************************
	localparam logic [4:0] REG_INT_TRIG  = 5'h03;                         // last write, integer ratio
	localparam logic [4:0] REG_FRAC_TRIG = 5'h04;                         // last write, fractional ratio
	localparam logic [4:0] REG_INDIRECT  = 5'h05;                         // indirect_subsystem_access

	// ***********************************************
	// indirect word layout
	// ***********************************************
	localparam logic [2:0] SUBSYS_OSC  = 3'h0;                            // subsystem_select of the oscillator
	localparam logic [3:0] SUB_BAND    = 4'h0;                            // band / tune sub-register
	localparam logic [3:0] SUB_PWR     = 4'h1;                            // oscillator_power_bias
	localparam logic [3:0] SUB_DIV     = 4'h2;                            // output_divider_control
	localparam logic [15:0] WORD_ZERO  = 16'h0000;                        // re-arm write
	localparam logic [4:0] DIV_RSVD    = 5'h00;                           // reserved divider bits 8:4
	localparam logic       PWR_RSVD    = 1'b0;                            // reserved power bit 7

	// sequence steps
	typedef enum logic [2:0] {
		OSCIW_STEP_ZERO,
		OSCIW_STEP_DIV,
		OSCIW_STEP_PWR,
		OSCIW_STEP_BAND,
		OSCIW_STEP_TRIG,
		OSCIW_STEP_END
	} osciw_step_t;

	// one full programming order from the user
	typedef struct packed {
		logic        freq_change;          // first programming or frequency change
		logic        fractional;           // detector ratio is fractional
		logic        band_change;          // band sub-register write wanted
		logic [2:0]  output_divide_ratio;  // divide code
		logic        oscillator_powerdown; // oscillator power down
		logic [1:0]  rf_pwr;               // main output level
		logic [2:0]  bias;                 // oscillator bias level
		logic [1:0]  div_pwr;              // divided output level
		logic        div_en;               // divider enable
		logic [7:0]  band_number;          // manual band
		logic        tune_source_select;   // tune voltage source
		logic [23:0] trig_data;            // data of the final trigger write
	} osciw_cfg_t;

endpackage

// >>> verilog/osciw_host.sv
`timescale 1ns/10ps
module osciw_host
(
	input  wire logic                  i_clk,   // system clock
	input  wire logic                  i_rst,   // asynchronous reset, active high
	input  wire logic                  i_start, // user asks for one programming sequence
	input  wire osciw_pkg::osciw_cfg_t i_cfg,   // settings of that sequence
	output logic                       o_ready, // a start given now is taken
	output logic                       o_busy,  // a sequence is running
	output logic                       o_done,  // one-cycle pulse at the end of a sequence
	output logic                       o_sclk,  // serial clock to the synthesizer
	output logic                       o_sdata, // serial data to the synthesizer
	output logic                       o_sen_n  // serial enable, active low
);

	// ***********************************************
	// local types
	// ***********************************************

	// phases of one serial frame
	typedef enum logic [2:0] {
		FR_IDLE,
		FR_LEAD,
		FR_LOW,
		FR_HIGH,
		FR_TRAIL,
		FR_GAP
	} osciw_frame_t;

	// ***********************************************
	// declarations
	// ***********************************************

	osciw_frame_t           fr_state;      // current frame phase
	osciw_frame_t           next_fr_state; // frame phase after this cycle
	osciw_pkg::osciw_step_t step;          // write of the sequence now being sent
	osciw_pkg::osciw_step_t next_step;     // write that follows the current one
	osciw_pkg::osciw_step_t first_step;    // opening write of a new sequence
	osciw_pkg::osciw_cfg_t  cfg_q;         // settings held for the whole sequence
	logic                   busy;          // sequence running
	logic                   launch;        // pulse: send the frame of the current step
	logic                   done_q;        // end-of-sequence pulse
	logic                   accept;        // start taken this cycle
	logic [4:0]             div_cnt;       // half period divider
	logic                   tick;          // one-cycle enable at each half period
	logic                   fr_active;     // a frame is on the wire
	logic                   load_frame;    // frame engine takes a new frame
	logic                   frame_done;    // frame engine finishes a frame
	logic                   last_bit;      // the last bit of the frame is on the wire
	logic [5:0]             bit_cnt;       // index of the bit on the wire
	logic [5:0]             next_bit_cnt;  // bit index after this cycle
	logic [31:0]            shift_reg;     // frame being shifted out msb first
	logic [31:0]            next_shift;    // shift register after this cycle
	logic                   next_sclk;     // serial clock after this cycle
	logic                   next_sen_n;    // serial enable after this cycle
	logic [15:0]            word_div;      // indirect word for the divider sub-register
	logic [15:0]            word_pwr;      // indirect word for the power/bias sub-register
	logic [15:0]            word_band;     // indirect word for the band sub-register
	logic [15:0]            word_sel;      // indirect word of the current step
	logic [4:0]             frame_addr;    // synthesizer register of the current step
	logic [23:0]            frame_data;    // data field of the current step
	logic [31:0]            frame_word;    // whole frame of the current step

	// ***********************************************
	// indirect word assembly
	// ***********************************************

	// divider word: reserved zeros, power down, ratio code, address, oscillator select
	assign word_div = {osciw_pkg::DIV_RSVD,
		cfg_q.oscillator_powerdown,
		cfg_q.output_divide_ratio,
		osciw_pkg::SUB_DIV,
		osciw_pkg::SUBSYS_OSC};

	// power word: enable, reserved zero, divided level, bias, main level
	assign word_pwr = {cfg_q.div_en,
		osciw_pkg::PWR_RSVD,
		cfg_q.div_pwr,
		cfg_q.bias,
		cfg_q.rf_pwr,
		osciw_pkg::SUB_PWR,
		osciw_pkg::SUBSYS_OSC};

	// band word: band number above the tune source bit
	assign word_band = {cfg_q.band_number,
		cfg_q.tune_source_select,
		osciw_pkg::SUB_BAND,
		osciw_pkg::SUBSYS_OSC};

	// word of the current step; the re-arm step sends all zeros
	assign word_sel = (step == osciw_pkg::OSCIW_STEP_ZERO) ? osciw_pkg::WORD_ZERO :
		(step == osciw_pkg::OSCIW_STEP_DIV) ? word_div :
		(step == osciw_pkg::OSCIW_STEP_PWR) ? word_pwr : word_band;

	// the trigger write goes to the integer or fractional register
	assign frame_addr = (step != osciw_pkg::OSCIW_STEP_TRIG) ? osciw_pkg::REG_INDIRECT :
		(cfg_q.fractional ? osciw_pkg::REG_FRAC_TRIG : osciw_pkg::REG_INT_TRIG);

	// indirect words sit in the low 16 data bits; upper data bits stay zero
	assign frame_data = (step == osciw_pkg::OSCIW_STEP_TRIG) ? cfg_q.trig_data : {8'h00, word_sel};

	// frame: data, register address, trailing chip field
	assign frame_word = {frame_data, frame_addr, osciw_pkg::FRAME_TAIL};

	// ***********************************************
	// sequence order
	// ***********************************************

	// start with the re-arm write only when the frequency changes
	assign first_step = i_cfg.freq_change ? osciw_pkg::OSCIW_STEP_ZERO : osciw_pkg::OSCIW_STEP_DIV;

	// divider, then power, then band if wanted, then the trigger write
	assign next_step = (step == osciw_pkg::OSCIW_STEP_ZERO) ? osciw_pkg::OSCIW_STEP_DIV :
		(step == osciw_pkg::OSCIW_STEP_DIV) ? osciw_pkg::OSCIW_STEP_PWR :
		(step == osciw_pkg::OSCIW_STEP_PWR) ?
		(cfg_q.band_change ? osciw_pkg::OSCIW_STEP_BAND : osciw_pkg::OSCIW_STEP_TRIG) :
		(step == osciw_pkg::OSCIW_STEP_BAND) ? osciw_pkg::OSCIW_STEP_TRIG : osciw_pkg::OSCIW_STEP_END;

	// a new sequence is taken only while idle
	assign accept  = i_start && !busy;
	assign o_ready = !busy;
	assign o_busy  = busy;
	assign o_done  = done_q;

	// sequence control: launches each frame and ends the sequence
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			busy   <= 1'b0;
			launch <= 1'b0;
			done_q <= 1'b0;
			step   <= osciw_pkg::OSCIW_STEP_ZERO;
			cfg_q  <= '0;
		end
		else
		begin
			launch <= 1'b0;
			done_q <= 1'b0;
			// latch the settings so a changing input cannot tear a sequence
			if (accept)
			begin
				busy   <= 1'b1;
				cfg_q  <= i_cfg;
				step   <= first_step;
				launch <= 1'b1;
			end
			// a frame has ended: go on or finish
			else if (frame_done)
			begin
				step <= next_step;
				if (next_step == osciw_pkg::OSCIW_STEP_END)
				begin
					busy   <= 1'b0;
					done_q <= 1'b1;
				end
				else
				begin
					launch <= 1'b1;
				end
			end
		end
	end

	// ***********************************************
	// serial frame engine
	// ***********************************************

	// decode of the frame engine
	assign fr_active  = (fr_state != FR_IDLE);
	assign tick       = fr_active && (div_cnt == osciw_pkg::DIV_LAST);
	assign last_bit   = (bit_cnt == osciw_pkg::BIT_LAST);
	assign load_frame = launch && (fr_state == FR_IDLE);
	assign frame_done = (fr_state == FR_GAP) && tick;
	assign next_sclk  = (next_fr_state == FR_HIGH);
	assign next_sen_n = (next_fr_state == FR_IDLE) || (next_fr_state == FR_GAP);

	// half period divider, only counts inside a frame
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			div_cnt <= 5'h00;
		else if (!fr_active || tick)
			div_cnt <= 5'h00;
		else
			div_cnt <= div_cnt + 5'h01;
	end

	// next phase, bit index and shift register
	always_comb
	begin
		next_fr_state = fr_state;
		next_bit_cnt  = bit_cnt;
		next_shift    = shift_reg;
		unique case (fr_state)
			// idle: take the frame of the current step
			FR_IDLE:
			begin
				if (load_frame)
				begin
					next_fr_state = FR_LEAD;
					next_bit_cnt  = 6'h00;
					next_shift    = frame_word;
				end
			end
			// enable low before the first clock edge
			FR_LEAD:
			begin
				if (tick)
					next_fr_state = FR_LOW;
			end
			// data settles while the clock is low
			FR_LOW:
			begin
				if (tick)
					next_fr_state = FR_HIGH;
			end
			// clock high: the device samples; then next bit or end
			FR_HIGH:
			begin
				if (tick)
				begin
					if (last_bit)
					begin
						next_fr_state = FR_TRAIL;
					end
					else
					begin
						next_fr_state = FR_LOW;
						next_bit_cnt  = bit_cnt + 6'h01;
						next_shift    = {shift_reg[30:0], 1'b0};
					end
				end
			end
			// hold enable after the last edge
			FR_TRAIL:
			begin
				if (tick)
					next_fr_state = FR_GAP;
			end
			// enable high: the device takes the whole word here
			FR_GAP:
			begin
				if (tick)
					next_fr_state = FR_IDLE;
			end
			// unused codes fall back to idle
			default:
			begin
				next_fr_state = FR_IDLE;
			end
		endcase
	end

	// frame registers and the registered pins
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			fr_state  <= FR_IDLE;
			bit_cnt   <= 6'h00;
			shift_reg <= 32'h00000000;
			o_sclk    <= 1'b0;
			o_sdata   <= 1'b0;
			o_sen_n   <= 1'b1;
		end
		else
		begin
			fr_state  <= next_fr_state;
			bit_cnt   <= next_bit_cnt;
			shift_reg <= next_shift;
			o_sclk    <= next_sclk;
			o_sdata   <= next_shift[31];
			o_sen_n   <= next_sen_n;
		end
	end

	// ***********************************************
	// assertions
	// ***********************************************

	// a rising serial clock edge
	sequence s_rise;
		!o_sclk ##1 o_sclk;
	endsequence

	// two cycles of high serial clock
	sequence s_high_pair;
		o_sclk ##1 o_sclk;
	endsequence

	// the last cycle of a frame
	sequence s_frame_end;
		(fr_state == FR_GAP) && tick;
	endsequence

	// rising clock edges happen only inside a frame
	property p_rise_selected;
		@(posedge i_clk) disable iff (i_rst) s_rise |-> !o_sen_n;
	endproperty
	a_rise_selected: assert property (p_rise_selected) else $error("clock edge outside frame");

	// data holds while the device samples
	property p_sdata_hold;
		@(posedge i_clk) disable iff (i_rst) s_high_pair |-> $stable(o_sdata);
	endproperty
	a_sdata_hold: assert property (p_sdata_hold) else $error("data moved while clock high");

	// every frame but the last is followed by the next one
	property p_relaunch;
		@(posedge i_clk) disable iff (i_rst) s_frame_end |=> (launch || o_done);
	endproperty
	a_relaunch: assert property (p_relaunch) else $error("sequence stalled after frame");

	// the end pulse comes with the bus idle
	property p_done_idle;
		@(posedge i_clk) disable iff (i_rst) o_done |-> (!o_busy && o_sen_n);
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("done while still busy");

	// indirect frames target the oscillator through the indirect register
	property p_osc_select;
		@(posedge i_clk) disable iff (i_rst)
		(load_frame && (step != osciw_pkg::OSCIW_STEP_TRIG)) |->
		((frame_word[10:8] == osciw_pkg::SUBSYS_OSC) && (frame_addr == osciw_pkg::REG_INDIRECT));
	endproperty
	a_osc_select: assert property (p_osc_select) else $error("indirect frame not for oscillator");

	// reserved divider bits go out as zero
	property p_div_rsvd;
		@(posedge i_clk) disable iff (i_rst)
		(load_frame && (step == osciw_pkg::OSCIW_STEP_DIV)) |-> (frame_word[23:19] == osciw_pkg::DIV_RSVD);
	endproperty
	a_div_rsvd: assert property (p_div_rsvd) else $error("divider reserved bits set");

	// reserved power bit goes out as zero
	property p_pwr_rsvd;
		@(posedge i_clk) disable iff (i_rst)
		(load_frame && (step == osciw_pkg::OSCIW_STEP_PWR)) |-> (frame_word[22] == osciw_pkg::PWR_RSVD);
	endproperty
	a_pwr_rsvd: assert property (p_pwr_rsvd) else $error("power reserved bit set");

	// the trigger write picks its register from the ratio kind
	property p_trig_addr;
		@(posedge i_clk) disable iff (i_rst)
		(load_frame && (step == osciw_pkg::OSCIW_STEP_TRIG)) |->
		(frame_word[7:3] == (cfg_q.fractional ? osciw_pkg::REG_FRAC_TRIG : osciw_pkg::REG_INT_TRIG));
	endproperty
	a_trig_addr: assert property (p_trig_addr) else $error("wrong trigger register");

endmodule // osciw_host

// >>> dv/osciw_dev_model.sv
`timescale 1ns/10ps
// device side: takes each frame msb first and keeps every indirect word
module osciw_dev_model
(
	input  wire logic i_sclk,
	input  wire logic i_sdata,
	input  wire logic i_sen_n
);
	logic [31:0] sr; // frame shift register
	logic [4:0]  la; // address of the last frame
	logic [15:0] q[$]; // indirect words as received
	always @(posedge i_sclk) if (!i_sen_n) sr <= {sr[30:0], i_sdata};
	always @(posedge i_sen_n) la <= sr[7:3];
	always @(posedge i_sen_n) if (sr[7:3] == osciw_pkg::REG_INDIRECT) q.push_back(sr[23:8]);
endmodule // osciw_dev_model

// >>> dv/oscillator_indirect_write_port_tb.sv
`timescale 1ns/10ps
module oscillator_indirect_write_port_tb;
	logic i_clk = 0, i_rst = 1, i_start = 0, o_ready, o_busy, o_done, o_sclk, o_sdata, o_sen_n;
	osciw_pkg::osciw_cfg_t i_cfg = '0;
	int err_total = 0, samples_checked = 0, cyc = 0;
	logic [15:0] exp[$]; // expected indirect words in order
	always #5 i_clk = ~i_clk;
	osciw_host osciw_host_inst (.i_clk, .i_rst, .i_start, .i_cfg,
		.o_ready, .o_busy, .o_done, .o_sclk, .o_sdata, .o_sen_n);
	osciw_dev_model osciw_dev_model_inst (.i_sclk(o_sclk), .i_sdata(o_sdata), .i_sen_n(o_sen_n));
	task automatic summarize(input int to);
		err_total += to;
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		err_total += int'(got !== want);
		if (got !== want) $display("[FAIL] %0t got %h want %h", $time, got, want);
	endtask
	always @(posedge i_clk) if (++cyc == 40000) summarize(1);
	initial
	begin
		void'($urandom(4228));
		repeat (3) @(posedge i_clk);
		#1 i_rst = 0;
		repeat (8)
		begin
			i_cfg = 48'({$urandom, $urandom});
			exp = {};
			if (i_cfg.freq_change) exp.push_back(16'h0000);
			exp.push_back({5'h00, i_cfg.oscillator_powerdown, i_cfg.output_divide_ratio, 7'h10});
			exp.push_back({i_cfg.div_en, 1'b0, i_cfg.div_pwr, i_cfg.bias, i_cfg.rf_pwr, 7'h08});
			if (i_cfg.band_change) exp.push_back({i_cfg.band_number, i_cfg.tune_source_select, 7'h00});
			wait (o_ready === 1'b1);
			@(posedge i_clk) #1 i_start = 1;
			@(posedge i_clk) #1 i_start = 0;
			wait (o_done === 1'b1);
			@(posedge i_clk) #1;
			chk(16'(osciw_dev_model_inst.q.size()), 16'(exp.size()));
			foreach (exp[k]) chk(osciw_dev_model_inst.q[k], exp[k]);
			chk({11'h0, osciw_dev_model_inst.la}, i_cfg.fractional ? 16'h0004 : 16'h0003);
			osciw_dev_model_inst.q.delete();
		end
		summarize(0);
	end
endmodule // oscillator_indirect_write_port_tb
